// ---- common/palette_if.sv ----
// I/O port link between the host and the color palette
`timescale 1ns/10ps
interface palette_if;
  logic [15:0] io_addr;   // Port address
  logic [7:0]  io_wdata;  // Write data
  logic        io_wr;     // Write strobe
  logic        io_rd;     // Read strobe
  logic [7:0]  io_rdata;  // Read data, cycle after io_rd
  modport dev  (input io_addr, io_wdata, io_wr, io_rd, output io_rdata);
  modport host (output io_addr, io_wdata, io_wr, io_rd, input io_rdata);
endinterface : palette_if

// ---- common/palette_pkg.sv ----
// Types shared by both ends of the color palette port
package palette_pkg;
  typedef logic [5:0]  comp_t;   // One 6-bit intensity
  typedef logic [7:0]  index_t;  // Entry index
  typedef logic [15:0] port_t;   // I/O port address
  typedef enum logic [1:0] {
    comp_red   = 2'h0,
    comp_green = 2'h1,
    comp_blue  = 2'h2
  } comp_sel_t;
  typedef enum logic [2:0] {
    h_idle  = 3'h0,
    h_index = 3'h1,
    h_data  = 3'h2,
    h_wait  = 3'h3,
    h_single = 3'h4
  } host_state_t;
endpackage : palette_pkg

// ---- common/palette_regs.svh ----
// Port offsets, field positions, reset values and codes for the color palette port
`ifndef PALETTE_REGS_SVH
`define PALETTE_REGS_SVH

`define PAL_MASK_OFS        16'h03c6
`define PAL_RD_INDEX_OFS    16'h03c7
`define PAL_WR_INDEX_OFS    16'h03c8
`define PAL_DATA_OFS        16'h03c9

`define PAL_MASK_RESET      8'hff
`define PAL_COMP_MSB        5
`define PAL_ENTRIES         256
`define PAL_LAST_WRITE      2'h0
`define PAL_LAST_READ       2'h3

`define CTL_INDEX_OFS       3'h0
`define CTL_RED_OFS         3'h1
`define CTL_GREEN_OFS       3'h2
`define CTL_BLUE_OFS        3'h3
`define CTL_GO_OFS          3'h4
`define CTL_STATUS_OFS      3'h5
`define CTL_MASK_OFS        3'h6

`define CTL_GO_WRITE_BIT    0
`define CTL_GO_READ_BIT     1
`define CTL_GO_MASK_WR_BIT  2
`define CTL_GO_MASK_RD_BIT  3
`define CTL_GO_STAT_RD_BIT  4

`endif

// ---- hdl/palette_host.sv ----
// Host end: runs index-and-three-component palette sequences from control registers
`timescale 1ns/10ps
`include "palette_regs.svh"
module palette_host (
  input  wire logic        mclk,      // System clock
  input  wire logic        rst_n,     // Synchronous reset, active low
  input  wire logic [2:0]  ctl_addr,  // Control register address
  input  wire logic [7:0]  ctl_wdata, // Control write data
  input  wire logic        ctl_wr,    // Control write strobe
  input  wire logic        ctl_rd,    // Control read strobe
  output logic [7:0]       ctl_rdata, // Control read data, cycle after ctl_rd
  palette_if.host          bus        // Palette ports
);
  palette_pkg::host_state_t state;      // Sequencer state
  logic [7:0]               index;      // Entry to address
  logic [17:0]              color;      // Red, green, blue
  logic [7:0]               mask;       // Mask value to write; a mask read-back lands in status_rd
  logic [7:0]               status_rd;  // Last single-port read result
  logic                     is_read;    // Sequence direction
  logic [1:0]               step;       // Component step
  logic [2:0]               single;     // Single-port op code
  logic                     busy;       // Sequence running
  logic                     take;       // Read answer stands on the link this cycle
  logic                     take_single; // That answer belongs to a single-port read
  logic [1:0]               take_step;  // Component step the answer belongs to

  // The device answers one cycle after the strobe edge, so the answer is taken one cycle after h_wait
  assign busy = state != palette_pkg::h_idle || take;

  // Marks the cycle in which the device's read answer stands on io_rdata
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      take        <= 1'b0;
      take_single <= 1'b0;
      take_step   <= 2'h0;
    end else begin
      take        <= state == palette_pkg::h_wait ||
                     (state == palette_pkg::h_single && single[0] == 1'b0 && bus.io_rd);
      take_single <= state == palette_pkg::h_single;
      take_step   <= step;
    end
  end

  // Control registers; writes ignored while busy, go only taken in h_idle, so a sequence is never split
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      index <= 8'h00;
      color <= 18'h00000;
      mask  <= `PAL_MASK_RESET;  // Default keeps mask at all ones
    end else if (take && !take_single) begin
      case (take_step)  // Answers land red, green, blue
        2'h0:    color[17:12] <= bus.io_rdata[5:0];
        2'h1:    color[11:6]  <= bus.io_rdata[5:0];
        default: color[5:0]   <= bus.io_rdata[5:0];
      endcase
    end else if (ctl_wr && !busy) begin
      case (ctl_addr)
        `CTL_INDEX_OFS: index        <= ctl_wdata;
        `CTL_RED_OFS:   color[17:12] <= ctl_wdata[5:0];
        `CTL_GREEN_OFS: color[11:6]  <= ctl_wdata[5:0];
        `CTL_BLUE_OFS:  color[5:0]   <= ctl_wdata[5:0];
        `CTL_MASK_OFS:  mask         <= ctl_wdata;
        default: ;
      endcase
    end
  end

  // Sequencer: index write, then three data accesses
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state     <= palette_pkg::h_idle;
      is_read   <= 1'b0;
      step      <= 2'h0;
      single    <= 3'h0;
      status_rd <= 8'h00;
      bus.io_addr  <= 16'h0000;
      bus.io_wdata <= 8'h00;
      bus.io_wr    <= 1'b0;
      bus.io_rd    <= 1'b0;
    end else begin
      bus.io_wr <= 1'b0;
      bus.io_rd <= 1'b0;
      case (state)
        palette_pkg::h_idle: begin
          if (ctl_wr && ctl_addr == `CTL_GO_OFS) begin
            single <= ctl_wdata[4:2];
            if (ctl_wdata[`CTL_GO_WRITE_BIT] || ctl_wdata[`CTL_GO_READ_BIT]) begin
              is_read <= ctl_wdata[`CTL_GO_READ_BIT] && !ctl_wdata[`CTL_GO_WRITE_BIT];
              state   <= palette_pkg::h_index;
            end else if (ctl_wdata[4:2] != 3'h0) begin
              state <= palette_pkg::h_single;
            end
          end
        end
        palette_pkg::h_index: begin
          bus.io_wr    <= 1'b1;
          bus.io_addr  <= is_read ? `PAL_RD_INDEX_OFS : `PAL_WR_INDEX_OFS;
          bus.io_wdata <= index;
          step         <= 2'h0;
          state        <= palette_pkg::h_data;
        end
        palette_pkg::h_data: begin
          bus.io_addr <= `PAL_DATA_OFS;
          if (is_read) begin
            bus.io_rd <= 1'b1;
            state     <= palette_pkg::h_wait;
          end else begin
            bus.io_wr <= 1'b1;
            case (step)  // Red, then green, then blue
              2'h0:    bus.io_wdata <= {2'h0, color[17:12]};
              2'h1:    bus.io_wdata <= {2'h0, color[11:6]};
              default: bus.io_wdata <= {2'h0, color[5:0]};
            endcase
            step  <= step + 2'h1;
            state <= (step == 2'h2) ? palette_pkg::h_idle : palette_pkg::h_data;
          end
        end
        palette_pkg::h_wait: begin
          // Strobe is seen by the device at this edge; answer is taken next cycle
          step  <= step + 2'h1;
          state <= (step == 2'h2) ? palette_pkg::h_idle : palette_pkg::h_data;
        end
        palette_pkg::h_single: begin
          if (single[0]) begin
            bus.io_wr    <= 1'b1;
            bus.io_addr  <= `PAL_MASK_OFS;
            bus.io_wdata <= mask;
            state        <= palette_pkg::h_idle;
          end else if (!bus.io_rd) begin
            bus.io_rd   <= 1'b1;
            bus.io_addr <= single[1] ? `PAL_MASK_OFS : `PAL_RD_INDEX_OFS;
          end else begin
            state <= palette_pkg::h_idle;
          end
        end
        default: begin
          state <= palette_pkg::h_idle;
        end
      endcase
      if (take && take_single) begin
        status_rd <= bus.io_rdata;  // Taken in the cycle in which the answer stands
      end
    end
  end

  // Control read answer, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl_rdata <= 8'h00;
    end else if (ctl_rd) begin
      case (ctl_addr)
        `CTL_INDEX_OFS:  ctl_rdata <= index;
        `CTL_RED_OFS:    ctl_rdata <= {2'h0, color[17:12]};
        `CTL_GREEN_OFS:  ctl_rdata <= {2'h0, color[11:6]};
        `CTL_BLUE_OFS:   ctl_rdata <= {2'h0, color[5:0]};
        `CTL_STATUS_OFS: ctl_rdata <= {7'h00, busy};
        `CTL_MASK_OFS:   ctl_rdata <= status_rd;
        default:         ctl_rdata <= 8'h00;
      endcase
    end else begin
      ctl_rdata <= 8'h00;
    end
  end
endmodule : palette_host

// ---- hdl/palette_port.sv ----
// Device end: 256-entry color palette reached through four I/O ports
`timescale 1ns/10ps
`include "palette_regs.svh"
module palette_port (
  input  wire logic              mclk,          // System clock
  input  wire logic              rst_n,         // Synchronous reset, active low
  palette_if.dev                 bus,           // Host I/O ports
  input  wire palette_pkg::index_t look_index,  // Pixel path lookup index
  output logic [17:0]            look_color,    // Registered entry, red high
  output logic [7:0]             pixel_mask     // Mask value to the pixel path
);
  // Entry storage; no reset, contents are loaded by software
  logic [17:0]             ram [0:`PAL_ENTRIES-1];
  palette_pkg::index_t     index;       // Active entry pointer
  palette_pkg::comp_sel_t  comp;        // Next component
  logic [11:0]             hold_wr;     // Red and green waiting for blue
  logic [1:0]              last_cycle;  // Last palette cycle type
  logic [7:0]              rdata;       // Read answer register
  logic [17:0]             rd_entry;    // Entry under the read pointer
  logic                    wr_data;     // Write to data port
  logic                    rd_data;     // Read of data port
  palette_pkg::comp_t      wcomp;       // Written intensity

  assign wr_data     = bus.io_wr && bus.io_addr == `PAL_DATA_OFS;
  assign rd_data     = bus.io_rd && bus.io_addr == `PAL_DATA_OFS;
  assign wcomp       = bus.io_wdata[`PAL_COMP_MSB:0];
  assign rd_entry    = ram[index];
  assign bus.io_rdata = rdata;

  // Pixel mask register, resets to all ones
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pixel_mask <= `PAL_MASK_RESET;
    end else if (bus.io_wr && bus.io_addr == `PAL_MASK_OFS) begin
      pixel_mask <= bus.io_wdata;  // Stored even though masking has no effect
    end
  end

  // Shared pointer and component sequence; read and write share one pointer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      index <= 8'h00;
      comp  <= palette_pkg::comp_red;
    end else if (bus.io_wr && (bus.io_addr == `PAL_RD_INDEX_OFS || bus.io_addr == `PAL_WR_INDEX_OFS)) begin
      index <= bus.io_wdata;
      comp  <= palette_pkg::comp_red;
    end else if (wr_data || rd_data) begin
      case (comp)
        palette_pkg::comp_red: begin
          comp <= palette_pkg::comp_green;
        end
        palette_pkg::comp_green: begin
          comp <= palette_pkg::comp_blue;
        end
        palette_pkg::comp_blue: begin
          comp  <= palette_pkg::comp_red;
          index <= index + 8'h01;  // Wraps 255 to 0 for bursts
        end
        default: begin
          comp <= palette_pkg::comp_red;
        end
      endcase
    end
  end

  // Red and green are held until blue arrives, so an entry changes whole
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_wr <= 12'h000;
    end else if (wr_data && comp == palette_pkg::comp_red) begin
      hold_wr[11:6] <= wcomp;
    end else if (wr_data && comp == palette_pkg::comp_green) begin
      hold_wr[5:0] <= wcomp;
    end
  end

  // Entry write on the blue access
  always_ff @(posedge mclk) begin
    if (wr_data && comp == palette_pkg::comp_blue) begin
      ram[index] <= {hold_wr, wcomp};
    end
  end

  // Last palette cycle type, shown at the read-index port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_cycle <= `PAL_LAST_WRITE;
    end else if (rd_data) begin
      last_cycle <= `PAL_LAST_READ;
    end else if (wr_data) begin
      last_cycle <= `PAL_LAST_WRITE;
    end
  end

  // Read answer, valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.io_rd) begin
      case (bus.io_addr)
        `PAL_MASK_OFS: begin
          rdata <= pixel_mask;
        end
        `PAL_RD_INDEX_OFS: begin
          rdata <= {6'h00, last_cycle};
        end
        `PAL_WR_INDEX_OFS: begin
          rdata <= index;
        end
        `PAL_DATA_OFS: begin
          case (comp)  // Red first, then green, then blue
            palette_pkg::comp_red:   rdata <= {2'h0, rd_entry[17:12]};
            palette_pkg::comp_green: rdata <= {2'h0, rd_entry[11:6]};
            default:                 rdata <= {2'h0, rd_entry[5:0]};
          endcase
        end
        default: begin
          rdata <= 8'h00;
        end
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Lookup for the pixel path, one cycle of latency
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      look_color <= 18'h00000;
    end else begin
      look_color <= ram[look_index];
    end
  end
endmodule : palette_port

// ---- tb/palette_checker.sv ----
// Concurrent checks on the I/O link between the palette host and the palette device
`timescale 1ns/10ps
`include "palette_regs.svh"
module palette_checker (
  input wire logic        mclk,     // System clock
  input wire logic        rst_n,    // Synchronous reset, active low
  input wire logic [15:0] io_addr,  // Port address
  input wire logic [7:0]  io_wdata, // Write data
  input wire logic        io_wr,    // Write strobe
  input wire logic        io_rd,    // Read strobe
  input wire logic [7:0]  io_rdata  // Read data
);
  logic [17:0] ram_sh [256];  // Shadow of the entries
  logic [7:0]  idx_sh;        // Shadow pointer
  logic [1:0]  cnt;           // Component in turn
  logic [11:0] rg;            // Held red and green
  logic        last_rd;       // Last data access was a read
  logic [7:0]  mask_sh;       // Shadow of the mask
  logic [5:0]  cur;           // Component the next read must give
  wire dat = (io_wr || io_rd) && io_addr == `PAL_DATA_OFS;
  wire idx = io_wr && (io_addr == `PAL_RD_INDEX_OFS || io_addr == `PAL_WR_INDEX_OFS);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Pointer, component turn and last cycle kind follow the link
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idx_sh <= 8'h00;
      cnt <= 2'h0;
      last_rd <= 1'b0;
    end else if (idx) begin
      idx_sh <= io_wdata;
      cnt <= 2'h0;
    end else if (dat) begin
      cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      idx_sh <= (cnt == 2'h2) ? idx_sh + 8'h01 : idx_sh;
      last_rd <= io_rd;
    end
  end
  // Mask shadow starts at all ones
  always_ff @(posedge mclk) begin
    if (!rst_n) mask_sh <= 8'hff;
    else if (io_wr && io_addr == `PAL_MASK_OFS) mask_sh <= io_wdata;
  end
  // Entries land whole at blue; unwritten ones stay unknown, so only written ones may be read
  always_ff @(posedge mclk) begin
    if (io_wr && io_addr == `PAL_DATA_OFS) begin
      if (cnt == 2'h0) rg[11:6] <= io_wdata[5:0];
      if (cnt == 2'h1) rg[5:0] <= io_wdata[5:0];
      if (cnt == 2'h2) ram_sh[idx_sh] <= {rg, io_wdata[5:0]};
    end
  end
  always_comb cur = cnt == 2'h0 ? ram_sh[idx_sh][17:12] : (cnt == 2'h1 ? ram_sh[idx_sh][11:6] : ram_sh[idx_sh][5:0]);

  a_rdata_rest: assert property (!io_rd |=> io_rdata == 8'h00) else $error("read data outside answer cycle");
  a_strobe_excl: assert property (!(io_wr && io_rd)) else $error("both strobes high");
  a_data_value: assert property (io_rd && io_addr == `PAL_DATA_OFS |=> io_rdata[5:0] == $past(cur))
    else $error("wrong component read");
  a_last_kind: assert property (io_rd && io_addr == `PAL_RD_INDEX_OFS |=>
    io_rdata == {6'h00, ($past(last_rd) ? `PAL_LAST_READ : `PAL_LAST_WRITE)}) else $error("wrong last cycle code");
  a_mask_read: assert property (io_rd && io_addr == `PAL_MASK_OFS |=> io_rdata == $past(mask_sh))
    else $error("wrong mask read");
  a_three_comps: assert property (idx |=> dat ##[1:2] dat ##[1:2] dat) else $error("index not followed by three data accesses");
  a_addr_mapped: assert property (io_wr || io_rd |-> io_addr inside {[`PAL_MASK_OFS:`PAL_DATA_OFS]})
    else $error("access outside palette ports");
  a_mask_full: assert property (io_wr && io_addr == `PAL_MASK_OFS |-> io_wdata == 8'hff)
    else $error("mask written with other than all ones");
  c_entry: cover property (idx ##1 dat ##1 dat ##1 dat);
  c_status: cover property (io_rd && io_addr == `PAL_RD_INDEX_OFS);
  c_mask: cover property (io_wr && io_addr == `PAL_MASK_OFS);
endmodule : palette_checker

// ---- tb/tb_color_palette_port.sv ----
// Self-checking bench: palette host and palette device joined over the I/O link
`timescale 1ns/10ps
`include "palette_regs.svh"
module tb_color_palette_port;
  logic                mclk;        // System clock
  logic                rst_n;       // Synchronous reset, active low
  logic [2:0]          ctl_addr;    // Control address
  logic [7:0]          ctl_wdata;   // Control write data
  logic                ctl_wr;      // Control write strobe
  logic                ctl_rd;      // Control read strobe
  logic [7:0]          ctl_rdata;   // Control read data
  palette_pkg::index_t look_index;  // Lookup index
  logic [17:0]         look_color;  // Lookup result
  logic [7:0]          pixel_mask;  // Mask output
  int                  n_fail;      // Mismatches
  int                  comparisons; // Compares made
  int                  cycles;      // Hang guard
  logic [7:0]          v;           // Last control read
  // Index, red, green, blue; upper bits set on purpose, they must be dropped
  logic [7:0] rows [4][4] = '{'{8'h00, 8'hc0, 8'h7f, 8'h95}, '{8'hff, 8'h2a, 8'hd5, 8'h40},
                              '{8'h0e, 8'hff, 8'h3f, 8'h55}, '{8'h7f, 8'h15, 8'h80, 8'hea}};

  palette_if u_palette_if ();
  palette_port u_palette_port (.mclk(mclk), .rst_n(rst_n), .bus(u_palette_if), .look_index(look_index),
                               .look_color(look_color), .pixel_mask(pixel_mask));
  palette_host u_palette_host (.mclk(mclk), .rst_n(rst_n), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
                               .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_rdata(ctl_rdata), .bus(u_palette_if));
  palette_checker u_palette_checker (.mclk(mclk), .rst_n(rst_n), .io_addr(u_palette_if.io_addr),
    .io_wdata(u_palette_if.io_wdata), .io_wr(u_palette_if.io_wr), .io_rd(u_palette_if.io_rd),
    .io_rdata(u_palette_if.io_rdata));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // A hung handshake ends the run as a failure
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // One-cycle write; a gap cycle keeps strobes from being set twice in one step
  task automatic cw(input logic [2:0] a, input logic [7:0] d);
    ctl_addr <= a;
    ctl_wdata <= d;
    ctl_wr <= 1'b1;
    @(posedge mclk);
    ctl_wr <= 1'b0;
    @(posedge mclk);
  endtask : cw
  // Read data is taken mid-cycle after the strobe, where it has settled
  task automatic cr(input logic [2:0] a, output logic [7:0] d);
    ctl_addr <= a;
    ctl_rd <= 1'b1;
    @(posedge mclk);
    ctl_rd <= 1'b0;
    @(negedge mclk);
    d = ctl_rdata;
    @(posedge mclk);
  endtask : cr
  // Start an operation and poll busy under a bound
  task automatic go(input logic [7:0] cmd);
    int i;
    cw(`CTL_GO_OFS, cmd);
    v = 8'h01;
    for (i = 0; i < 30 && v[0] !== 1'b0; i++) cr(`CTL_STATUS_OFS, v);
    check(v[0], 1'b0);
  endtask : go
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    {rst_n, ctl_addr, ctl_wdata, ctl_wr, ctl_rd, look_index} = '0;
    {n_fail, comparisons, cycles} = '0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // Each row: store, fetch back, look up, and check the last cycle code both ways
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) cw(k[2:0], rows[r][k]);
      go(8'h01);
      go(8'h10);
      cr(`CTL_MASK_OFS, v);
      check(v, {6'h00, `PAL_LAST_WRITE});
      look_index <= rows[r][0];
      go(8'h02);
      for (int k = 1; k < 4; k++) begin
        cr(k[2:0], v);
        check(v, {2'h0, rows[r][k][5:0]});
      end
      check(look_color, {rows[r][1][5:0], rows[r][2][5:0], rows[r][3][5:0]});
      go(8'h10);
      cr(`CTL_MASK_OFS, v);
      check(v, {6'h00, `PAL_LAST_READ});
      $display("row %0d done", r);
    end
    // Mask comes up all ones and is left there
    check(pixel_mask, `PAL_MASK_RESET);
    cw(`CTL_MASK_OFS, 8'hff);
    go(8'h04);
    go(8'h08);
    cr(`CTL_MASK_OFS, v);
    check(v, 8'hff);
    $display("mask test done");
    // Reset in mid-run: mask and last cycle code return, entries survive
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check(pixel_mask, `PAL_MASK_RESET);
    go(8'h10);
    cr(`CTL_MASK_OFS, v);
    check(v, {6'h00, `PAL_LAST_WRITE});
    cw(3'h0, rows[1][0]);
    go(8'h02);
    cr(3'h3, v);
    check(v, {2'h0, rows[1][3][5:0]});
    $display("second reset test done");
    finish_test();
  end
endmodule : tb_color_palette_port
